// File: verilog/pwmeg_pkg.sv
// Purpose: constants and state type for pwm edge shaping and oring gate control
// Assumes: 100 MHz core clock, 256-tick switching period
// Notes: offsets are the register port addresses
package pwmeg_pkg;
    localparam int CLK_NS = 10;
    localparam int NUM_OUT = 7;
    localparam int NUM_EDGE = 14;
    // register addresses
    localparam logic [7:0] ADDR_MOD_LIMITS = 8'h2e;
    localparam logic [7:0] ADDR_ORING_THR = 8'h30;
    localparam logic [7:0] ADDR_LIGHT_LOAD = 8'h3b;
    localparam logic [7:0] ADDR_TIMING_LATCH = 8'h5d;
    localparam logic [7:0] ADDR_ADT_THR = 8'h68;
    localparam logic [7:0] ADDR_OFS_FIRST = 8'h69;
    localparam logic [7:0] ADDR_OFS_LAST = 8'h6f;
    // field positions
    localparam int LATCH_BIT = 0;
    localparam int MOD_HIGH_LSB = 0;
    localparam int MOD_LOW_LSB = 4;
    localparam int FAST_THR_LSB = 0;
    localparam int EN_THR_LSB = 4;
    localparam int OFS_W = 4;
    // one limit step is 1/16 of the period (16 ticks)
    localparam int LIMIT_STEP_SHIFT = 4;
    // rectifier outputs sit at output index 5 and 6
    localparam int SR_ONE = 5;
    localparam int SR_TWO = 6;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // outputs blanked for one period while new timing is applied
    localparam int BLANK_NS = 2560;
    localparam logic [8:0] BLANK_CYC = 9'((BLANK_NS + CLK_NS - 1) / CLK_NS);
    // sense code for nominal 12 V output; arbitrary scaling
    localparam int NOM_CODE = 2000;
    localparam logic signed [12:0] EN_THR_M05 = -13'(NOM_CODE / 200);
    localparam logic signed [12:0] EN_THR_0 = 13'sd0;
    localparam logic signed [12:0] EN_THR_1 = 13'(NOM_CODE / 100);
    localparam logic signed [12:0] EN_THR_2 = 13'(NOM_CODE / 50);

    typedef struct packed {
        logic [7:0] modlim_sh;
        logic [7:0] modlim_act;
        logic [7:0] oring_thr;
        logic [7:0] light_thr;
        logic [7:0] adt_thr;
        logic [55:0] ofs_sh;
        logic [55:0] ofs_act;
        logic [7:0] phase;
        logic [8:0] blank;
        logic [111:0] pos;
        logic [6:0] skip;
        logic [6:0] pwm;
        logic light;
        logic gate_on;
        logic ov_hold;
        logic [7:0] rdata;
    } pwmeg_state_t;
endpackage : pwmeg_pkg

// File: verilog/pwmeg_top.sv
// Purpose: adaptive edge offsets, light-load shedding, modulation limits, oring gate
// Assumes: synchronous inputs, register port writes and reads in one cycle
// Notes: Contract
// Contract
// R1 - offsets only while modulation below threshold
// R2 - signed per-edge offset added to nominal
// R3 - rectifier outputs off below light-load threshold
// R4 - selected other outputs also shed
// R5 - light-load filter set selected in light load
// R6 - each edge kept within max/min limits
// R7 - limits are nominal plus/minus period percentage
// R8 - skip pulse when below minimum, if enabled
// R9 - gate off until start-up criteria met
// R10 - selected fault flags turn switch off
// R11 - fast comparator trip turns switch off
// R12 - accurate reverse voltage above zero disables
// R13 - forward drop above threshold enables switch
// R14 - four threshold settings of nominal voltage
// R15 - software uses accurate path in normal mode
// R16 - software uses line-sense fault in light load
// R17 - fast path first on internal short
// R18 - overvoltage: switch off, regulate local, re-enable
// R19 - timing takes effect on latch, outputs blanked
// R20 - threshold codes ascend through listed values
// R21 - clamping applied after adaptive offset
`timescale 1ns/100ps
`default_nettype none
module pwmeg_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // modulation and load
    input wire logic [7:0] modulation,
    input wire logic [7:0] load_current,
    input wire logic signed [7:0] mod_delta,
    input wire logic [13:0] mod_edge_mask,
    input wire logic [111:0] edge_nominal,
    input wire logic skip_enable,
    input wire logic [4:0] shed_select,
    // pwm outputs, index 5 and 6 are the rectifier drives
    output logic [6:0] pwm_out,
    output logic light_filter_select,
    // oring sense and faults
    input wire logic startup_ok,
    input wire logic [11:0] local_sense_voltage,
    input wire logic [11:0] downstream_sense_voltage,
    input wire logic fast_reverse_trip,
    input wire logic signed [11:0] secondary_current_sense_reverse,
    input wire logic [7:0] fault_flags,
    input wire logic [7:0] fault_select,
    input wire logic bus_overvoltage,
    output logic [3:0] fast_threshold,
    output logic regulate_local,
    // oring gate pin, open drain
    input wire logic gate_in,
    output logic gate_out,
    output logic gate_oe
);
    import pwmeg_pkg::*;

    pwmeg_state_t s_reg;
    pwmeg_state_t s_next;

    function automatic logic is_ofs(input logic [7:0] a);
        is_ofs = (a >= ADDR_OFS_FIRST) && (a <= ADDR_OFS_LAST);
    endfunction : is_ofs

    function automatic logic signed [12:0] en_thr(input logic [1:0] code);
        case (code)
            2'd0: en_thr = EN_THR_M05; // R14 R20
            2'd1: en_thr = EN_THR_0;
            2'd2: en_thr = EN_THR_1;
            default: en_thr = EN_THR_2;
        endcase
    endfunction : en_thr

    // clamp into [lo,hi] and into the period
    function automatic logic [7:0] clamp(input logic signed [10:0] v,
            input logic signed [10:0] lo, input logic signed [10:0] hi);
        logic signed [10:0] r;
        r = v;
        if (r > hi) r = hi;
        if (r < lo) r = lo;
        if (r < 0) r = '0;
        if (r > 11'sd255) r = 11'sd255;
        clamp = r[7:0];
    endfunction : clamp

    logic adapt;
    logic light_now;
    logic [111:0] edge_pos;
    logic [13:0] edge_low;

    assign adapt = modulation < s_reg.adt_thr; // R1
    assign light_now = load_current < s_reg.light_thr;

    genvar e;
    generate
        for (e = 0; e < NUM_EDGE; e++) begin : g_edge
            logic signed [10:0] nom;
            logic signed [10:0] ofs;
            logic signed [10:0] md;
            logic signed [10:0] want;
            logic signed [10:0] hi;
            logic signed [10:0] lo;
            assign nom = {3'b000, edge_nominal[e*8 +: 8]};
            assign ofs = adapt ? 11'(signed'(s_reg.ofs_act[e*OFS_W +: OFS_W])) : '0; // R2
            assign md = mod_edge_mask[e] ? 11'(mod_delta) : '0;
            assign want = nom + ofs + md;
            assign hi = nom + (11'(s_reg.modlim_act[MOD_HIGH_LSB +: 4]) << LIMIT_STEP_SHIFT); // R7
            assign lo = nom - (11'(s_reg.modlim_act[MOD_LOW_LSB +: 4]) << LIMIT_STEP_SHIFT); // R7
            // offset first, then clamp, so adaptive moves never escape the window
            assign edge_pos[e*8 +: 8] = clamp(want, lo, hi); // R6 R21
            assign edge_low[e] = want < lo;
        end
    endgenerate

    logic signed [12:0] fwd_drop;
    logic kill;
    assign fwd_drop = signed'({1'b0, local_sense_voltage}) - signed'({1'b0, downstream_sense_voltage});
    assign kill = fast_reverse_trip // R11
        || (secondary_current_sense_reverse > 12'sd0) // R12
        || (|(fault_flags & fault_select)) // R10
        || bus_overvoltage; // R18

    always_comb begin
        logic [7:0] rise;
        logic [7:0] fall;
        logic shed;
        s_next = s_reg;
        rise = '0;
        fall = '0;
        shed = 1'b0;
        s_next.rdata = '0;
        // register port
        if (reg_wr) begin
            case (reg_addr)
                ADDR_MOD_LIMITS: s_next.modlim_sh = reg_wdata;
                ADDR_ORING_THR: s_next.oring_thr = reg_wdata;
                ADDR_LIGHT_LOAD: s_next.light_thr = reg_wdata;
                ADDR_ADT_THR: s_next.adt_thr = reg_wdata;
                default: begin
                    if (is_ofs(reg_addr))
                        s_next.ofs_sh[(reg_addr - ADDR_OFS_FIRST)*8 +: 8] = reg_wdata;
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_MOD_LIMITS: s_next.rdata = s_reg.modlim_sh;
                ADDR_ORING_THR: s_next.rdata = s_reg.oring_thr;
                ADDR_LIGHT_LOAD: s_next.rdata = s_reg.light_thr;
                ADDR_ADT_THR: s_next.rdata = s_reg.adt_thr;
                default: begin
                    if (is_ofs(reg_addr))
                        s_next.rdata = s_reg.ofs_sh[(reg_addr - ADDR_OFS_FIRST)*8 +: 8];
                end
            endcase
        end
        // new timing goes live together; blank outputs meanwhile
        if (reg_wr && reg_addr == ADDR_TIMING_LATCH && reg_wdata[LATCH_BIT]) begin
            s_next.modlim_act = s_reg.modlim_sh; // R19
            s_next.ofs_act = s_reg.ofs_sh; // R19
            s_next.blank = BLANK_CYC; // R19
        end else if (s_reg.blank != '0) begin
            s_next.blank = s_reg.blank - 9'd1;
        end
        // period counter; positions sampled at wrap so edges never move mid-cycle
        s_next.phase = s_reg.phase + 8'd1;
        if (s_reg.phase == 8'hff) begin
            s_next.pos = edge_pos;
            s_next.light = light_now; // R5
            for (int k = 0; k < NUM_OUT; k++)
                s_next.skip[k] = skip_enable && (edge_low[2*k] || edge_low[2*k+1]); // R8
        end
        for (int k = 0; k < NUM_OUT; k++) begin
            rise = s_reg.pos[(2*k)*8 +: 8];
            fall = s_reg.pos[(2*k+1)*8 +: 8];
            if (k == SR_ONE || k == SR_TWO)
                shed = s_reg.light; // R3
            else
                shed = s_reg.light && shed_select[k]; // R4
            s_next.pwm[k] = (s_reg.blank == '0) && !s_reg.skip[k] && !shed
                && (s_reg.phase >= rise) && (s_reg.phase < fall);
        end
        // oring switch
        s_next.ov_hold = bus_overvoltage ? (s_reg.ov_hold || s_reg.gate_on) : 1'b0;
        if (!startup_ok) begin
            s_next.gate_on = 1'b0; // R9
        end else if (kill) begin
            s_next.gate_on = 1'b0; // R10 R11 R12
        end else if (s_reg.ov_hold) begin
            s_next.gate_on = 1'b1; // R18
        end else if (fwd_drop > en_thr(s_reg.oring_thr[EN_THR_LSB +: 2])) begin
            s_next.gate_on = 1'b1; // R13
        end
        if (rst) begin
            s_next = '0;
            s_next.modlim_sh = RST_REG;
            s_next.modlim_act = RST_REG;
            s_next.oring_thr = RST_REG;
            s_next.light_thr = RST_REG;
            s_next.adt_thr = RST_REG;
        end
    end

    always_ff @(posedge core_clk) begin
        s_reg <= s_next;
    end

    assign reg_rdata = s_reg.rdata;
    assign pwm_out = s_reg.pwm;
    assign light_filter_select = s_reg.light; // R5
    assign fast_threshold = s_reg.oring_thr[FAST_THR_LSB +: 4];
    // pin reads back high until the external driver really pulls low
    assign regulate_local = !s_reg.gate_on || gate_in || bus_overvoltage; // R18
    assign gate_out = 1'b0;
    assign gate_oe = s_reg.gate_on; // R9
endmodule : pwmeg_top
`default_nettype wire

// File: verif/pwmeg_top_asserts.sv
// Purpose: port checker for pwmeg_top
// Assumes: one clock, rst sync high
// Notes: bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module pwmeg_top_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // inputs
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic startup_ok,
    input wire logic fast_reverse_trip,
    input wire logic signed [11:0] secondary_current_sense_reverse,
    input wire logic [7:0] fault_flags,
    input wire logic [7:0] fault_select,
    input wire logic bus_overvoltage,
    // outputs
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] pwm_out,
    input wire logic regulate_local,
    input wire logic gate_out,
    input wire logic gate_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_start; !startup_ok |=> !gate_oe; endproperty
    a_start: assert property (p_start) else $error("gate on early");
    property p_pin; gate_oe |-> !gate_out; endproperty
    a_pin: assert property (p_pin) else $error("pin not low");
    property p_flag; |(fault_flags & fault_select) |=> !gate_oe; endproperty
    a_flag: assert property (p_flag) else $error("flag kept gate");
    property p_fast; fast_reverse_trip |=> !gate_oe; endproperty
    a_fast: assert property (p_fast) else $error("fast trip kept gate");
    property p_acc; secondary_current_sense_reverse > 0 |=> !gate_oe; endproperty
    a_acc: assert property (p_acc) else $error("reverse kept gate");
    property p_ov; bus_overvoltage |-> regulate_local ##1 !gate_oe; endproperty
    a_ov: assert property (p_ov) else $error("overvoltage response");
    property p_blank;
        reg_wr && reg_addr == 8'h5d && reg_wdata[0] |-> ##2 (pwm_out == 7'h00) [*8];
    endproperty
    a_blank: assert property (p_blank) else $error("no blanking");
    property p_rdl; reg_rd && reg_addr == 8'h5d |=> reg_rdata == 8'h00; endproperty
    a_rdl: assert property (p_rdl) else $error("latch read");
    c_off: cover property (gate_oe ##1 !gate_oe);
    c_ov: cover property (bus_overvoltage ##1 !bus_overvoltage);
    c_sr: cover property (pwm_out[5] ##1 !pwm_out[5]);
endmodule : pwmeg_top_asserts
`default_nettype wire

// File: verif/pwmeg_stage.sv
// Purpose: far side of the gate pin
// Assumes: pull-up on the pin
// Notes: released pin reads high, never the last value
`timescale 1ns/100ps
`default_nettype none
module pwmeg_stage (
    // pin drive
    input wire logic gate_out,
    input wire logic gate_oe,
    // pin level
    output logic gate_pin
);
    assign gate_pin = gate_oe ? gate_out : 1'b1;
endmodule : pwmeg_stage
`default_nettype wire

// File: verif/pwmeg_tb.sv
// Purpose: self-checking bench for pwmeg_top
// Assumes: 100 MHz clock, sync reset
// Notes: widths compared with an integer model
`timescale 1ns/100ps
`default_nettype none
module pwmeg_tb;
    import pwmeg_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, sk = 0, su = 0, ft = 0, ov = 0, lf, rl, go, oe, gp;
    logic [7:0] ad = 0, wd = 0, mo = 0, ld = 8'hff, ff = 0, fs = 0, rdat, a, d;
    logic signed [7:0] dl = 0;
    logic signed [11:0] sr = 0;
    logic [111:0] nom = 0;
    logic [11:0] ds = 12'd1000;
    logic [4:0] sh = 0;
    logic [6:0] pw;
    logic [3:0] fthr;
    int err_total = 0, n_tests = 0, seed = 32'h11ce, w;
    int thr[4] = '{-10, 0, 20, 40};
    int md[5] = '{16, 128, 16, 144, 144};
    int dt[5] = '{0, 0, 100, -120, -120};
    logic [7:0] al[4] = '{8'h2e, 8'h30, 8'h3b, 8'h68};
    always #5 clk = ~clk;
    pwmeg_top u_pwmeg_top (.core_clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad),
        .reg_wdata(wd), .reg_rdata(rdat), .modulation(mo), .load_current(ld), .mod_delta(dl),
        .mod_edge_mask(14'h0002), .edge_nominal(nom), .skip_enable(sk), .shed_select(sh),
        .pwm_out(pw), .light_filter_select(lf), .startup_ok(su), .local_sense_voltage(12'd1000),
        .downstream_sense_voltage(ds), .fast_reverse_trip(ft),
        .secondary_current_sense_reverse(sr), .fault_flags(ff), .fault_select(fs),
        .bus_overvoltage(ov), .fast_threshold(fthr), .regulate_local(rl), .gate_in(gp),
        .gate_out(go), .gate_oe(oe));
    pwmeg_stage u_pwmeg_stage (.gate_out(go), .gate_oe(oe), .gate_pin(gp));
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
        end
    endtask : chk
    task automatic wrr(input logic [7:0] x, input logic [7:0] v);
        @(posedge clk);
        wr <= 1;
        ad <= x;
        wd <= v;
        @(posedge clk);
        wr <= 0;
    endtask : wrr
    task automatic rchk(input logic [7:0] x, input logic [7:0] e);
        @(posedge clk);
        rd <= 1;
        ad <= x;
        @(posedge clk);
        rd <= 0;
        @(negedge clk);
        chk(rdat, e);
    endtask : rchk
    // gate on means pin low and regulation from the remote point
    task automatic gchk(input logic e);
        repeat (2) @(negedge clk);
        chk(!gp, e);
        chk(rl, !e);
        @(posedge clk);
    endtask : gchk
    task automatic meas(input int k, input int e);
        w = 0;
        repeat (512) @(posedge clk);
        repeat (256) begin
            @(negedge clk);
            w += (pw[k] === 1'b1);
        end
        chk(9'(w), 9'(e));
    endtask : meas
    // limits are one step each side; offsets +2 rise, -3 fall
    function automatic int ew(int m, int x, bit s);
        int r, f, uf, l;
        l = 1 << LIMIT_STEP_SHIFT;
        r = 16 + (m < 128 ? 2 : 0);
        uf = 128 + (m < 128 ? -3 : 0) + x;
        f = uf > 128 + l ? 128 + l : (uf < 128 - l ? 128 - l : uf);
        return (s && uf < 128 - l) ? 0 : f - r;
    endfunction : ew
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 11; i++) begin
            a = i < 4 ? al[i] : 8'(8'h65 + i);
            d = 8'($random(seed));
            rchk(a, RST_REG);
            wrr(a, d);
            rchk(a, d);
            wrr(a, 8'h00);
        end
        rchk(8'h5d, 8'h00);
        wrr(8'h69, 8'hd2);
        wrr(8'h2e, 8'h11);
        wrr(8'h68, 8'h80);
        wrr(8'h3b, 8'h40);
        nom <= {16'h0000, 16'hc800, 64'h0, 16'h8010};
        wrr(8'h5d, 8'h01);
        for (int i = 0; i < 5; i++) begin
            mo <= 8'(md[i]);
            dl <= 8'(dt[i]);
            sk <= i == 4;
            meas(0, ew(md[i], dt[i], i == 4));
        end
        meas(5, 200);
        ld <= 8'h10;
        sk <= 0;
        meas(0, 96);
        meas(5, 0);
        chk(lf, 1);
        sh <= 5'h01;
        meas(0, 0);
        gchk(0);
        su <= 1;
        fs <= 8'h01;
        for (int c = 0; c < 4; c++) begin
            wrr(8'h30, 8'(c * 16 + 5));
            ff <= 8'h01;
            gchk(0);
            ff <= 8'h00;
            ds <= 12'(1000 - thr[c]);
            gchk(0);
            ds <= 12'(999 - thr[c]);
            gchk(1);
        end
        chk(fthr, 5);
        for (int i = 0; i < 8; i++) begin
            ff <= 8'(1 << i);
            fs <= ~8'(1 << i);
            gchk(1);
            fs <= 8'hff;
            gchk(0);
            ff <= 8'h00;
            gchk(1);
        end
        ft <= 1;
        gchk(0);
        ft <= 0;
        gchk(1);
        sr <= 12'sd1;
        gchk(0);
        sr <= 12'sd0;
        gchk(1);
        ov <= 1;
        ds <= 12'd1000;
        gchk(0);
        ov <= 0;
        gchk(1);
        results();
    end
endmodule : pwmeg_tb
bind pwmeg_top pwmeg_top_asserts u_pwmeg_top_asserts (.core_clk(core_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .startup_ok(startup_ok), .fast_reverse_trip(fast_reverse_trip),
    .secondary_current_sense_reverse(secondary_current_sense_reverse),
    .fault_flags(fault_flags), .fault_select(fault_select), .bus_overvoltage(bus_overvoltage),
    .reg_rdata(reg_rdata), .pwm_out(pwm_out), .regulate_local(regulate_local),
    .gate_out(gate_out), .gate_oe(gate_oe));
`default_nettype wire
